// ==== design/ctr_pkg.sv ====
// package of offsets, field layouts, reset values and decoded value types
package ctr_pkg;
   localparam int unsigned CTR_ADDR_W = 8;
   localparam logic [7:0] CTR_RANGE_TWO_IDX = 8'h06;
   localparam logic [7:0] CTR_RANGE_THREE_IDX = 8'h07;
   // byte address is four times the register index
   localparam logic [7:0] CTR_RANGE_TWO_ADDR = {CTR_RANGE_TWO_IDX[5:0], 2'b00};
   localparam logic [7:0] CTR_RANGE_THREE_ADDR =
      {CTR_RANGE_THREE_IDX[5:0], 2'b00};
   localparam logic [7:0] CTR_RANGE_TWO_RST = 8'h4b;
   localparam logic [7:0] CTR_RANGE_THREE_RST = 8'hbf;
   localparam int unsigned CTR_THR_LSB = 5;
   localparam int unsigned CTR_VOLT_LSB = 3;
   localparam int unsigned CTR_CUR_LSB = 0;
   localparam logic [1:0] CTR_RESP_OKAY = 2'h0;
   localparam logic [1:0] CTR_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [2:0] threshold;
      logic [1:0] term_voltage;
      logic [2:0] charge_current;
   } ctr_range_cfg_s;

   // threshold code to degrees celsius; -128 marks an unlisted code
   typedef logic signed [7:0] ctr_degc_t;
   // termination feedback voltage in millivolts
   typedef logic [11:0] ctr_mv_t;
   // charge current in eighths of the programmed current; 15 = unlisted
   typedef logic [3:0] ctr_eighths_t;

   localparam ctr_degc_t CTR_DEGC_NONE = 8'sh80;
   localparam ctr_eighths_t CTR_EIGHTHS_NONE = 4'hf;
endpackage

// ==== design/ctr_decode.sv ====
// decoder of one range's codes into threshold, voltage and current values
module ctr_decode
   import ctr_pkg::*;
(
   input wire ctr_range_cfg_s cfg,
   output ctr_degc_t threshold_degc,
   output ctr_mv_t term_mv,
   output ctr_eighths_t current_eighths
);
   always_comb
   begin
      case (cfg.threshold)
         3'h1: threshold_degc = 8'sh00;
         3'h2: threshold_degc = 8'sh0a;
         3'h3: threshold_degc = 8'sh0f;
         3'h4: threshold_degc = 8'sh28;
         3'h5: threshold_degc = 8'sh2d;
         3'h6: threshold_degc = 8'sh32;
         default: threshold_degc = CTR_DEGC_NONE;
      endcase
   end

   always_comb
   begin
      case (cfg.term_voltage)
         2'h0: term_mv = 12'h7d0;
         2'h1: term_mv = 12'h802;
         2'h2: term_mv = 12'h81b;
         default: term_mv = 12'h834;
      endcase
   end

   always_comb
   begin
      case (cfg.charge_current)
         3'h0: current_eighths = 4'h0;
         3'h1: current_eighths = 4'h2;
         3'h2: current_eighths = 4'h3;
         3'h3: current_eighths = 4'h4;
         3'h4: current_eighths = 4'h5;
         3'h5: current_eighths = 4'h6;
         3'h6: current_eighths = 4'h7;
         default: current_eighths = CTR_EIGHTHS_NONE;
      endcase
   end
endmodule

// ==== design/ctr_regs.sv ====
// axi4-lite register bank for two charger temperature-range configurations
// Function
// - Threshold 0x06[7:5] is 0,10,15,40,45,50 C for 001..110, reset 010.
// - Third threshold at 0x07 bits 7:5 uses that table and resets to 101.
// - Voltage 0x07[4:3] picks 2.0,2.05,2.075,2.1 V for 00..11, reset 11.
// - Voltage 0x06[4:3] uses the same encoding and resets to 01.
// - Current 0x06[2:0] picks 0 to 87.5 percent for 000..110, reset 011.
// - Current 0x07[2:0] uses the same encoding and resets to 111.
//
// Our own choice: the AXI4-Lite interface to the registers.
module ctr_regs
   import ctr_pkg::*;
(
   input wire logic clock,
   input wire logic rstn,
   input wire logic [CTR_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [CTR_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output ctr_range_cfg_s low_mid_cfg,
   output ctr_range_cfg_s mid_high_cfg,
   output ctr_degc_t second_temp_threshold_degc,
   output ctr_degc_t third_temp_threshold_degc,
   output ctr_mv_t low_mid_range_term_mv,
   output ctr_mv_t mid_high_range_term_mv,
   output ctr_eighths_t low_mid_range_current_eighths,
   output ctr_eighths_t mid_high_range_current_eighths
);
   logic [7:0] range_two_r;
   logic [7:0] range_three_r;
   logic [CTR_ADDR_W-1:0] awaddr_r;
   logic aw_held_r;
   logic [7:0] wdata_r;
   logic wstrb0_r;
   logic w_held_r;
   logic do_write;
   logic [1:0] sel_w;
   logic [1:0] sel_r;
   ctr_degc_t thr2_c;
   ctr_degc_t thr3_c;
   ctr_mv_t v12_c;
   ctr_mv_t v23_c;
   ctr_eighths_t i12_c;
   ctr_eighths_t i23_c;

   // one-hot select: bit0 range two, bit1 range three
   function automatic logic [1:0] reg_sel(input logic [CTR_ADDR_W-1:0] a);
      reg_sel = {a == CTR_RANGE_THREE_ADDR, a == CTR_RANGE_TWO_ADDR};
   endfunction

   // write address and data may come in either order; each is held once taken
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         aw_held_r <= 1'b0;
         awaddr_r <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end
      else if (do_write)
         aw_held_r <= 1'b0;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         w_held_r <= 1'b0;
         wdata_r <= '0;
         wstrb0_r <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held_r <= 1'b1;
         wdata_r <= s_axi_wdata[7:0];
         wstrb0_r <= s_axi_wstrb[0];
      end
      else if (do_write)
         w_held_r <= 1'b0;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
      end
      else
      begin
         s_axi_awready <= !aw_held_r && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready <= !w_held_r && !s_axi_wready && !s_axi_bvalid;
      end
   end

   assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
   assign sel_w = reg_sel(awaddr_r);

   // storage: any code is kept as written, including unlisted ones
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         range_two_r <= CTR_RANGE_TWO_RST;
         range_three_r <= CTR_RANGE_THREE_RST;
      end
      else if (do_write && wstrb0_r)
      begin
         if (sel_w[0])
            range_two_r <= wdata_r;
         if (sel_w[1])
            range_three_r <= wdata_r;
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= CTR_RESP_OKAY;
      end
      else if (do_write)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= (|sel_w) ? CTR_RESP_OKAY : CTR_RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   assign sel_r = reg_sel(s_axi_araddr);

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= CTR_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= (|sel_r) ? CTR_RESP_OKAY : CTR_RESP_SLVERR;
            s_axi_rdata <= {24'h00_0000,
               (sel_r[0] ? range_two_r : 8'h00) |
               (sel_r[1] ? range_three_r : 8'h00)};
         end
         else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   ctr_decode u_dec_low_mid (
      .cfg(ctr_range_cfg_s'(range_two_r)),
      .threshold_degc(thr2_c),
      .term_mv(v12_c),
      .current_eighths(i12_c)
   );

   ctr_decode u_dec_mid_high (
      .cfg(ctr_range_cfg_s'(range_three_r)),
      .threshold_degc(thr3_c),
      .term_mv(v23_c),
      .current_eighths(i23_c)
   );

   // registered copies so every output leaves a flip-flop
   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         low_mid_cfg <= ctr_range_cfg_s'(CTR_RANGE_TWO_RST);
         mid_high_cfg <= ctr_range_cfg_s'(CTR_RANGE_THREE_RST);
         second_temp_threshold_degc <= 8'sh0a;
         third_temp_threshold_degc <= 8'sh2d;
         low_mid_range_term_mv <= 12'h802;
         mid_high_range_term_mv <= 12'h834;
         low_mid_range_current_eighths <= 4'h4;
         mid_high_range_current_eighths <= CTR_EIGHTHS_NONE;
      end
      else
      begin
         low_mid_cfg <= ctr_range_cfg_s'(range_two_r);
         mid_high_cfg <= ctr_range_cfg_s'(range_three_r);
         second_temp_threshold_degc <= thr2_c;
         third_temp_threshold_degc <= thr3_c;
         low_mid_range_term_mv <= v12_c;
         mid_high_range_term_mv <= v23_c;
         low_mid_range_current_eighths <= i12_c;
         mid_high_range_current_eighths <= i23_c;
      end
   end

   default clocking @(posedge clock);
   endclocking
   default disable iff (!rstn);

   sequence s_write_done;
      do_write && wstrb0_r && sel_w[0];
   endsequence

   a_thr2_decode: assert property (
      range_two_r[7:5] == 3'h6 |=> second_temp_threshold_degc == 8'sh32)
      else $error("second threshold decode wrong");
   a_thr3_decode: assert property (
      range_three_r[7:5] == 3'h1 |=> third_temp_threshold_degc == 8'sh00)
      else $error("third threshold decode wrong");
   a_v23_decode: assert property (
      range_three_r[4:3] == 2'h2 |=> mid_high_range_term_mv == 12'h81b)
      else $error("mid-high voltage decode wrong");
   a_v12_decode: assert property (
      range_two_r[4:3] == 2'h0 |=> low_mid_range_term_mv == 12'h7d0)
      else $error("low-mid voltage decode wrong");
   a_i12_decode: assert property (
      range_two_r[2:0] == 3'h2 |=>
      low_mid_range_current_eighths == 4'h3)
      else $error("low-mid current decode wrong");
   a_i23_decode: assert property (
      range_three_r[2:0] == 3'h5 |=>
      mid_high_range_current_eighths == 4'h6)
      else $error("mid-high current decode wrong");
   a_write_stores: assert property (
      s_write_done |=> range_two_r == $past(wdata_r) ##1
      low_mid_cfg == $past(wdata_r, 2))
      else $error("written value not stored");
   a_read_back: assert property (
      s_axi_arvalid && s_axi_arready && sel_r[1] |=>
      s_axi_rvalid && s_axi_rdata[7:0] == $past(range_three_r))
      else $error("read data mismatch");
endmodule

// ==== dv/ctr_regs_test.sv ====
// self-checking bench for the charger temperature-range register bank
module ctr_regs_test
   import ctr_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, rd_d;
   ctr_range_cfg_s low_mid_cfg, mid_high_cfg;
   ctr_degc_t thr2, thr3;
   ctr_mv_t mv2, mv3;
   ctr_eighths_t cur2, cur3;
   logic [7:0] v2, v3;
   int mismatches = 0;
   int cmp_count = 0;

   always #25 clock = ~clock;

   ctr_regs dut (.clock(clock), .rstn(rstn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .low_mid_cfg(low_mid_cfg),
      .mid_high_cfg(mid_high_cfg), .second_temp_threshold_degc(thr2),
      .third_temp_threshold_degc(thr3), .low_mid_range_term_mv(mv2),
      .mid_high_range_term_mv(mv3), .low_mid_range_current_eighths(cur2),
      .mid_high_range_current_eighths(cur3));

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask

   // address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [3:0] s, output logic [1:0] r);
      @(posedge clock);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {24'h00_0000, d};
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge clock);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge clock);
         if (arready)
            arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic rchk(input string n, input logic [7:0] a,
                       input logic [7:0] e);
      rd(a, rd_d, resp);
      chk(n, {24'h00_0000, e}, rd_d);
      chk("read resp", {30'h0, CTR_RESP_OKAY}, {30'h0, resp});
   endtask

   function automatic logic [7:0] degc(input logic [2:0] c);
      case (c)
         3'h1: degc = 8'h00;
         3'h2: degc = 8'h0a;
         3'h3: degc = 8'h0f;
         3'h4: degc = 8'h28;
         3'h5: degc = 8'h2d;
         3'h6: degc = 8'h32;
         default: degc = 8'h80;
      endcase
   endfunction

   function automatic logic [11:0] mvf(input logic [1:0] c);
      case (c)
         2'h0: mvf = 12'h7d0;
         2'h1: mvf = 12'h802;
         2'h2: mvf = 12'h81b;
         default: mvf = 12'h834;
      endcase
   endfunction

   // eighths of the programmed current; unlisted code reads 15
   function automatic logic [3:0] eig(input logic [2:0] c);
      eig = (c == 3'h0) ? 4'h0 : (c == 3'h7) ? 4'hf : {1'b0, c} + 4'h1;
   endfunction

   task automatic ochk(input logic [7:0] a, input logic [7:0] b);
      chk("low mid cfg", {24'h0, a}, {24'h0, low_mid_cfg});
      chk("mid high cfg", {24'h0, b}, {24'h0, mid_high_cfg});
      chk("second thr", {24'h0, degc(a[7:5])}, {24'h0, thr2});
      chk("third thr", {24'h0, degc(b[7:5])}, {24'h0, thr3});
      chk("low mid mv", {20'h0, mvf(a[4:3])}, {20'h0, mv2});
      chk("mid high mv", {20'h0, mvf(b[4:3])}, {20'h0, mv3});
      chk("low mid cur", {28'h0, eig(a[2:0])}, {28'h0, cur2});
      chk("mid high cur", {28'h0, eig(b[2:0])}, {28'h0, cur3});
   endtask

   initial
   begin
      repeat (10) @(posedge clock);
      rstn <= 1'b1;
      rchk("two reset", CTR_RANGE_TWO_ADDR, CTR_RANGE_TWO_RST);
      rchk("three reset", CTR_RANGE_THREE_ADDR, CTR_RANGE_THREE_RST);
      ochk(CTR_RANGE_TWO_RST, CTR_RANGE_THREE_RST);
      $display("test reset values done");
      for (int i = 0; i < 8; i++)
      begin
         v2 = {i[2:0], i[1:0], i[2:0]};
         v3 = ~v2;
         wr(CTR_RANGE_TWO_ADDR, v2, 4'h1, resp);
         chk("write resp", {30'h0, CTR_RESP_OKAY}, {30'h0, resp});
         wr(CTR_RANGE_THREE_ADDR, v3, 4'hf, resp);
         chk("write resp", {30'h0, CTR_RESP_OKAY}, {30'h0, resp});
         rchk("two readback", CTR_RANGE_TWO_ADDR, v2);
         rchk("three readback", CTR_RANGE_THREE_ADDR, v3);
         ochk(v2, v3);
      end
      $display("test code tables done");
      wr(8'h20, 8'h55, 4'hf, resp);
      chk("unmapped wr resp", {30'h0, CTR_RESP_SLVERR}, {30'h0, resp});
      rd(8'h20, rd_d, resp);
      chk("unmapped rdata", 32'h0000_0000, rd_d);
      chk("unmapped rd resp", {30'h0, CTR_RESP_SLVERR}, {30'h0, resp});
      wr(CTR_RANGE_TWO_ADDR, 8'h00, 4'h0, resp);
      rchk("masked write", CTR_RANGE_TWO_ADDR, v2);
      $display("test unmapped and masked done");
      @(posedge clock);
      rstn <= 1'b0;
      repeat (2) @(posedge clock);
      rstn <= 1'b1;
      rchk("two rereset", CTR_RANGE_TWO_ADDR, CTR_RANGE_TWO_RST);
      rchk("three rereset", CTR_RANGE_THREE_ADDR, CTR_RANGE_THREE_RST);
      $display("test second reset done");
      summarize();
   end

   // the tests need well under a thousand cycles
   initial
   begin
      repeat (5000) @(posedge clock);
      mismatches++;
      summarize();
   end
endmodule
